/* hw/crypto_pkg.sv */
package crypto_pkg;

	// cipher key build-up
	localparam int VEC_BITS = 24;
	localparam int SECRET_BITS = 232;
	localparam int CKEY_BITS = 256;
	localparam logic [23:0] VEC_RESET = 24'h000000;
	localparam logic [5:0] CKEY_B_SHORT = 6'h08;
	localparam logic [5:0] CKEY_B_LONG = 6'h10;
	localparam logic [5:0] CKEY_B_152 = 6'h13;
	localparam logic [5:0] CKEY_B_256 = 6'h20;
	localparam logic [7:0] SBOX_LAST = 8'hff;
	localparam logic [11:0] KSA_LAST_CYCLE = 12'h3ff;

	// integrity checksum
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam logic [31:0] CRC_POLY = 32'hedb88320;
	localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;
	localparam logic [1:0] ICV_LAST = 2'h3;

	typedef enum logic [1:0] {
		KL_SHORT = 2'b00, // 40-bit secret
		KL_LONG = 2'b01, // 104-bit secret
		KL_128 = 2'b10,
		KL_232 = 2'b11
	} key_len_t;

	typedef struct packed {
		logic [SECRET_BITS-1:0] secret;
		key_len_t len;
	} key_slot_t;

	typedef struct packed {
		logic [7:0] data;
		logic last;
	} beat_t;

	typedef enum logic [3:0] {
		S_IDLE = 4'b0000,
		S_FILL = 4'b0001,
		S_K_RI = 4'b0010,
		S_K_RJ = 4'b0011,
		S_K_W1 = 4'b0100,
		S_K_W2 = 4'b0101,
		S_G_WAIT = 4'b0110,
		S_G_RJ = 4'b0111,
		S_G_W1 = 4'b1000,
		S_G_W2 = 4'b1001,
		S_G_RD = 4'b1010,
		S_G_OUT = 4'b1011
	} state_t;

	// cipher key length in bytes for a secret length
	function automatic logic [5:0] ckey_bytes(input key_len_t len);
		case (len)
			KL_SHORT: ckey_bytes = CKEY_B_SHORT;
			KL_LONG: ckey_bytes = CKEY_B_LONG;
			KL_128: ckey_bytes = CKEY_B_152;
			default: ckey_bytes = CKEY_B_256;
		endcase
	endfunction

	// reflected crc-32, one byte
	function automatic logic [31:0] crc_byte(input logic [31:0] crc,
			input logic [7:0] d);
		logic [31:0] c;
		c = crc ^ {24'h000000, d};
		for (int b = 0; b < 8; b++) begin
			c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		crc_byte = c;
	endfunction

endpackage

/* hw/sbox_ram.sv */
`timescale 1ns/1ps
`default_nettype none

// 256 x 8 state table, write-first registered read
module sbox_ram (
	input wire logic I_CLK,
	input wire logic I_RESET_N,
	input wire logic i_we,
	input wire logic [7:0] i_waddr,
	input wire logic [7:0] i_wdata,
	input wire logic [7:0] i_raddr,
	output logic [7:0] o_rdata
);

	logic [7:0] mem [256];

	// storage write
	always_ff @(posedge I_CLK) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	// read with bypass so a swap is seen at once
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			o_rdata <= 8'h00;
		end else if (i_we && i_waddr == i_raddr) begin
			o_rdata <= i_wdata;
		end else begin
			o_rdata <= mem[i_raddr];
		end
	end

endmodule // sbox_ram
`default_nettype wire

/* hw/packet_crypto.sv */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [RULE1] the generator takes a cipher key of 8 to 2048 bits and yields a fixed byte stream; here it takes 64, 128, 152 or 256 bits only.
// [RULE2] transmit encrypts each byte by xor with the next stream byte.
// [RULE3] receive rebuilds the same stream from the same key and xors it back.
// [RULE4] one generator and xor path serve both directions, never at once.
// [RULE5] the cipher key is the shared secret joined with a per-packet vector.
// [RULE6] the sender steps the vector by one per packet and sends it in clear.
// [RULE7] the receiver joins the received vector with its secret to rebuild the key.
// [RULE8] the sender appends a checksum of the plain packet, encrypted with it.
// [RULE9] the receiver checks the checksum after decryption and flags failures for discard.
// [RULE10] the vector is 24 bits wide.
// [RULE11] a 40-bit secret gives a 64-bit cipher key.
// [RULE12] a 104-bit secret gives a 128-bit cipher key.
// [RULE13] 128-bit and 232-bit secrets are accepted as well.
// [RULE14] four secrets are held and the index sent with the packet picks one.
// [RULE15] the checksum is a 32-bit crc appended as the last four bytes.
module packet_crypto (
	input wire logic I_CLK,
	input wire logic I_RESET_N,
	input wire logic I_KEY_WR,
	input wire logic [1:0] I_KEY_IDX,
	input wire logic [crypto_pkg::SECRET_BITS-1:0] I_KEY_SECRET,
	input wire logic [1:0] I_KEY_LEN,
	input wire logic I_START,
	input wire logic I_DIR_RX,
	input wire logic [1:0] I_KEY_SEL,
	input wire logic [crypto_pkg::VEC_BITS-1:0] I_RX_VECTOR,
	input wire logic I_IN_VALID,
	input wire logic [7:0] I_IN_DATA,
	input wire logic I_IN_LAST,
	output logic O_IN_READY,
	output logic O_OUT_VALID,
	output logic [7:0] O_OUT_DATA,
	output logic O_OUT_LAST,
	input wire logic I_OUT_READY,
	output logic O_BUSY,
	output logic [crypto_pkg::VEC_BITS-1:0] O_TX_VECTOR,
	output logic [1:0] O_TX_KEY_SEL,
	output logic O_RX_DONE,
	output logic O_RX_DISCARD
);

	crypto_pkg::state_t state_reg;
	crypto_pkg::key_slot_t slot_reg [4];
	crypto_pkg::key_slot_t slot;
	crypto_pkg::beat_t beat_reg;
	logic dir_rx_reg;
	logic [1:0] sel_reg;
	logic [23:0] vec_reg;
	logic [23:0] tx_vec_reg;
	logic [7:0] i_reg;
	logic [7:0] j_reg;
	logic [7:0] si_reg;
	logic [7:0] sj_reg;
	logic [4:0] kidx_reg;
	logic [31:0] crc_reg;
	logic crc_phase_reg;
	logic [1:0] icv_cnt_reg;
	logic [7:0] out_data_reg;
	logic out_last_reg;
	logic [7:0] rdata;
	logic we;
	logic [7:0] waddr;
	logic [7:0] wdata;
	logic [7:0] raddr;
	logic [crypto_pkg::CKEY_BITS-1:0] ckey;
	logic [7:0] key_byte;
	logic [5:0] key_len;
	logic take;
	logic give;
	logic [7:0] plain;
	logic [31:0] crc_next;
	logic start_ok;

	////////////////////////////////////////////////////////////////////
	// secret slots, one per index
	generate
		for (genvar k = 0; k < 4; k++) begin : g_slot
			always_ff @(posedge I_CLK or negedge I_RESET_N) begin
				if (!I_RESET_N) begin
					slot_reg[k] <= '0;
				end else if (I_KEY_WR && I_KEY_IDX == 2'(k)) begin
					slot_reg[k] <= {I_KEY_SECRET, I_KEY_LEN}; // RULE11 RULE12 RULE13
				end
			end
		end
	endgenerate

	// cipher key: vector in the first three bytes, secret after
	assign slot = slot_reg[sel_reg]; // RULE14
	assign ckey = {slot.secret, vec_reg}; // RULE5 RULE10
	assign key_byte = ckey[{kidx_reg, 3'b000} +: 8];
	assign key_len = crypto_pkg::ckey_bytes(slot.len); // RULE1

	// handshakes
	assign start_ok = I_START && state_reg == crypto_pkg::S_IDLE;
	assign O_IN_READY = state_reg == crypto_pkg::S_G_WAIT && !crc_phase_reg;
	assign take = O_IN_READY && I_IN_VALID;
	assign O_OUT_VALID = state_reg == crypto_pkg::S_G_OUT;
	assign give = O_OUT_VALID && I_OUT_READY;
	assign O_OUT_DATA = out_data_reg;
	assign O_OUT_LAST = out_last_reg;
	assign O_BUSY = state_reg != crypto_pkg::S_IDLE;
	assign plain = dir_rx_reg ? out_data_reg : beat_reg.data;
	assign crc_next = crypto_pkg::crc_byte(crc_reg, plain);

	////////////////////////////////////////////////////////////////////
	// state table port control
	always_comb begin
		we = 1'b0;
		waddr = i_reg;
		wdata = rdata;
		raddr = i_reg;
		case (state_reg)
			crypto_pkg::S_FILL: begin
				we = 1'b1;
				wdata = i_reg;
			end
			crypto_pkg::S_K_RJ: raddr = 8'(j_reg + rdata + key_byte); // RULE1
			crypto_pkg::S_K_W1, crypto_pkg::S_G_W1: we = 1'b1;
			crypto_pkg::S_K_W2: begin
				we = 1'b1;
				waddr = j_reg;
				wdata = si_reg;
			end
			crypto_pkg::S_G_WAIT: raddr = 8'(i_reg + 8'h01);
			crypto_pkg::S_G_RJ: raddr = 8'(j_reg + rdata);
			crypto_pkg::S_G_W2: begin
				we = 1'b1;
				waddr = j_reg;
				wdata = si_reg;
				raddr = 8'(si_reg + sj_reg);
			end
			default: ;
		endcase
	end

	sbox_ram u_sbox (
		.I_CLK(I_CLK),
		.I_RESET_N(I_RESET_N),
		.i_we(we),
		.i_waddr(waddr),
		.i_wdata(wdata),
		.i_raddr(raddr),
		.o_rdata(rdata)
	);

	////////////////////////////////////////////////////////////////////
	// sequencer: fill, key schedule, then one byte per pass
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			state_reg <= crypto_pkg::S_IDLE;
			i_reg <= 8'h00;
			j_reg <= 8'h00;
			si_reg <= 8'h00;
			sj_reg <= 8'h00;
			kidx_reg <= 5'h00;
		end else begin
			case (state_reg)
				crypto_pkg::S_IDLE: begin
					i_reg <= 8'h00;
					if (start_ok) begin
						state_reg <= crypto_pkg::S_FILL; // RULE4
					end
				end
				crypto_pkg::S_FILL: begin
					i_reg <= 8'(i_reg + 8'h01);
					j_reg <= 8'h00;
					kidx_reg <= 5'h00;
					if (i_reg == crypto_pkg::SBOX_LAST) begin
						state_reg <= crypto_pkg::S_K_RI;
					end
				end
				crypto_pkg::S_K_RI: state_reg <= crypto_pkg::S_K_RJ;
				crypto_pkg::S_K_RJ: begin
					si_reg <= rdata;
					j_reg <= raddr;
					state_reg <= crypto_pkg::S_K_W1;
				end
				crypto_pkg::S_K_W1: state_reg <= crypto_pkg::S_K_W2;
				crypto_pkg::S_K_W2: begin
					i_reg <= 8'(i_reg + 8'h01);
					kidx_reg <= (6'(kidx_reg) == 6'(key_len - 6'h01)) ?
						5'h00 : 5'(kidx_reg + 5'h01); // RULE5
					if (i_reg == crypto_pkg::SBOX_LAST) begin
						j_reg <= 8'h00;
						state_reg <= crypto_pkg::S_G_WAIT;
					end else begin
						state_reg <= crypto_pkg::S_K_RI;
					end
				end
				crypto_pkg::S_G_WAIT: begin
					if (take || crc_phase_reg) begin
						i_reg <= raddr;
						state_reg <= crypto_pkg::S_G_RJ;
					end
				end
				crypto_pkg::S_G_RJ: begin
					si_reg <= rdata;
					j_reg <= raddr;
					state_reg <= crypto_pkg::S_G_W1;
				end
				crypto_pkg::S_G_W1: begin
					sj_reg <= rdata;
					state_reg <= crypto_pkg::S_G_W2;
				end
				crypto_pkg::S_G_W2: state_reg <= crypto_pkg::S_G_RD;
				crypto_pkg::S_G_RD: state_reg <= crypto_pkg::S_G_OUT;
				crypto_pkg::S_G_OUT: begin
					if (give) begin
						state_reg <= out_last_reg ? crypto_pkg::S_IDLE :
							crypto_pkg::S_G_WAIT;
					end
				end
				default: state_reg <= crypto_pkg::S_IDLE;
			endcase
		end
	end

	// packet context: direction, key slot, vector
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			dir_rx_reg <= 1'b0;
			sel_reg <= 2'b00;
			vec_reg <= crypto_pkg::VEC_RESET;
			tx_vec_reg <= crypto_pkg::VEC_RESET;
		end else if (start_ok) begin
			dir_rx_reg <= I_DIR_RX;
			sel_reg <= I_KEY_SEL; // RULE14
			if (I_DIR_RX) begin
				vec_reg <= I_RX_VECTOR; // RULE7
			end else begin
				vec_reg <= tx_vec_reg;
				tx_vec_reg <= 24'(tx_vec_reg + 24'h000001); // RULE6
			end
		end
	end
	assign O_TX_VECTOR = vec_reg; // RULE6
	assign O_TX_KEY_SEL = sel_reg;

	// byte capture: input data, or checksum bytes after the last one
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			beat_reg <= '0;
		end else if (take) begin
			beat_reg <= {I_IN_DATA, I_IN_LAST && dir_rx_reg};
		end else if (state_reg == crypto_pkg::S_G_WAIT && crc_phase_reg) begin
			beat_reg <= {~crc_reg[{icv_cnt_reg, 3'b000} +: 8],
				icv_cnt_reg == crypto_pkg::ICV_LAST}; // RULE8 RULE15
		end
	end

	// xor with the keystream byte, held until accepted
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			out_data_reg <= 8'h00;
			out_last_reg <= 1'b0;
		end else if (state_reg == crypto_pkg::S_G_RD) begin
			out_data_reg <= beat_reg.data ^ rdata; // RULE2 RULE3
			out_last_reg <= beat_reg.last;
		end
	end

	// checksum over the plain bytes
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			crc_reg <= crypto_pkg::CRC_INIT;
			crc_phase_reg <= 1'b0;
			icv_cnt_reg <= 2'b00;
		end else if (start_ok) begin
			crc_reg <= crypto_pkg::CRC_INIT;
			crc_phase_reg <= 1'b0;
			icv_cnt_reg <= 2'b00;
		end else if (take && I_IN_LAST && !dir_rx_reg) begin
			crc_phase_reg <= 1'b1; // RULE8
			crc_reg <= crypto_pkg::crc_byte(crc_reg, I_IN_DATA);
		end else if (take && !dir_rx_reg) begin // rx folds bytes on output
			crc_reg <= crypto_pkg::crc_byte(crc_reg, I_IN_DATA);
		end else if (state_reg == crypto_pkg::S_G_WAIT && crc_phase_reg) begin
			icv_cnt_reg <= 2'(icv_cnt_reg + 2'b01); // RULE15
		end else if (give && dir_rx_reg) begin
			crc_reg <= crc_next; // RULE9
		end
	end

	// receive verdict on the last byte
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_RX_DONE <= 1'b0;
			O_RX_DISCARD <= 1'b0;
		end else begin
			O_RX_DONE <= give && dir_rx_reg && out_last_reg;
			O_RX_DISCARD <= give && dir_rx_reg && out_last_reg &&
				crc_next != crypto_pkg::CRC_RESIDUE; // RULE9
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RESET_N);

	logic [11:0] ksa_cnt;
	always_ff @(posedge I_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			ksa_cnt <= 12'h000;
		end else if (state_reg == crypto_pkg::S_FILL) begin
			ksa_cnt <= 12'h000;
		end else if (state_reg inside {crypto_pkg::S_K_RI,
				crypto_pkg::S_K_RJ, crypto_pkg::S_K_W1, crypto_pkg::S_K_W2}) begin
			ksa_cnt <= 12'(ksa_cnt + 12'h001);
		end
	end

	sequence tx_start_s;
		start_ok && !I_DIR_RX;
	endsequence
	sequence tx_last_s;
		take && I_IN_LAST && !dir_rx_reg;
	endsequence
	sequence icv_wait_s;
		crc_phase_reg && icv_cnt_reg == 2'b00;
	endsequence
	sequence icv_first_s;
		state_reg == crypto_pkg::S_G_WAIT && crc_phase_reg &&
			icv_cnt_reg == 2'b00;
	endsequence

	ksa_length_a: assert property (state_reg == crypto_pkg::S_K_W2 && // RULE1
		i_reg == crypto_pkg::SBOX_LAST |-> ksa_cnt == crypto_pkg::KSA_LAST_CYCLE)
		else $error("key schedule did not take 1024 cycles");
	xor_path_a: assert property (state_reg == crypto_pkg::S_G_RD |=> // RULE2
		O_OUT_DATA == ($past(beat_reg.data) ^ $past(rdata)) && O_OUT_VALID)
		else $error("output byte is not data xor keystream");
	rx_vector_a: assert property (start_ok && I_DIR_RX |=> // RULE7
		vec_reg == $past(I_RX_VECTOR) && dir_rx_reg)
		else $error("receive vector not taken");
	tx_vector_a: assert property (tx_start_s |=> // RULE6
		tx_vec_reg == 24'(O_TX_VECTOR + 24'h000001))
		else $error("vector not stepped by one");
	key_wrap_a: assert property (state_reg == crypto_pkg::S_K_W2 && // RULE5
		6'(kidx_reg) == 6'(key_len - 6'h01) |=> kidx_reg == 5'h00)
		else $error("key byte index did not wrap");
	icv_tail_a: assert property (tx_last_s |=> icv_wait_s ##[1:1000] // RULE8
		icv_first_s)
		else $error("checksum tail does not start at its first byte");
	icv_order_a: assert property (icv_first_s |=> // RULE15
		beat_reg.data == ~crc_reg[7:0] && !beat_reg.last)
		else $error("first checksum byte is not the low byte");
	rx_verdict_a: assert property (O_RX_DISCARD |-> O_RX_DONE && // RULE9
		$past(dir_rx_reg) && $past(O_OUT_LAST))
		else $error("discard without receive end");
	one_way_a: assert property (O_IN_READY |-> O_BUSY && // RULE4
		state_reg == crypto_pkg::S_G_WAIT && !O_OUT_VALID)
		else $error("input and output active together");
	slot_pick_a: assert property (start_ok |=> // RULE14
		sel_reg == $past(I_KEY_SEL) && O_TX_KEY_SEL == sel_reg)
		else $error("key slot not selected");

endmodule // packet_crypto
`default_nettype wire

/* testbench/peer_sink.sv */
`timescale 1ns/1ps
`default_nettype none

// peer side taking the decrypted or encrypted byte stream
module peer_sink (
	input wire logic I_CLK,
	input wire logic I_RESET_N,
	input wire logic i_stall,
	input wire logic i_valid,
	input wire logic [7:0] i_data,
	input wire logic i_last,
	output logic o_ready
);
	logic [8:0] beats [$];

	// ready changes off the sampling edge, stalls at random when asked
	always @(negedge I_CLK) begin
		o_ready <= i_stall ? 1'($urandom % 2) : 1'b1;
	end

	// every accepted byte is kept whole with its last flag
	always @(posedge I_CLK) begin
		if (I_RESET_N && i_valid && o_ready) begin
			beats.push_back({i_data, i_last});
		end
	end
endmodule // peer_sink

`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
	logic I_CLK = 0, I_RESET_N = 0, I_KEY_WR = 0, I_START = 0, I_DIR_RX = 0;
	logic I_IN_VALID = 0, I_IN_LAST = 0, stall = 0;
	logic [1:0] I_KEY_IDX = 0, I_KEY_LEN = 0, I_KEY_SEL = 0;
	logic [crypto_pkg::SECRET_BITS-1:0] I_KEY_SECRET = '0;
	logic [23:0] I_RX_VECTOR = 0, tv = 0;
	logic [7:0] I_IN_DATA = 0;
	logic O_IN_READY, O_OUT_VALID, O_OUT_LAST, O_BUSY, O_RX_DONE, O_RX_DISCARD;
	logic I_OUT_READY;
	logic [7:0] O_OUT_DATA;
	logic [23:0] O_TX_VECTOR;
	logic [1:0] O_TX_KEY_SEL;
	int errors = 0, checked = 0, cycles = 0;
	logic [255:0] sec [4];
	logic [1:0] kl [4];
	logic [7:0] ks [64];

	packet_crypto packet_crypto_inst (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
		.I_KEY_WR(I_KEY_WR), .I_KEY_IDX(I_KEY_IDX),
		.I_KEY_SECRET(I_KEY_SECRET), .I_KEY_LEN(I_KEY_LEN),
		.I_START(I_START), .I_DIR_RX(I_DIR_RX), .I_KEY_SEL(I_KEY_SEL),
		.I_RX_VECTOR(I_RX_VECTOR), .I_IN_VALID(I_IN_VALID),
		.I_IN_DATA(I_IN_DATA), .I_IN_LAST(I_IN_LAST),
		.O_IN_READY(O_IN_READY), .O_OUT_VALID(O_OUT_VALID),
		.O_OUT_DATA(O_OUT_DATA), .O_OUT_LAST(O_OUT_LAST),
		.I_OUT_READY(I_OUT_READY), .O_BUSY(O_BUSY),
		.O_TX_VECTOR(O_TX_VECTOR), .O_TX_KEY_SEL(O_TX_KEY_SEL),
		.O_RX_DONE(O_RX_DONE), .O_RX_DISCARD(O_RX_DISCARD));
	peer_sink peer_sink_inst (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
		.i_stall(stall), .i_valid(O_OUT_VALID), .i_data(O_OUT_DATA),
		.i_last(O_OUT_LAST), .o_ready(I_OUT_READY));

	// 10 MHz clock and hang guard
	always #50 I_CLK = ~I_CLK;
	always @(posedge I_CLK) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			complete_run;
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// cipher key bytes for each secret length
	function automatic int klen(input logic [1:0] l);
		return l == 2'h0 ? 8 : l == 2'h1 ? 16 : l == 2'h2 ? 19 : 32;
	endfunction

	function automatic logic [31:0] crc_upd(input logic [31:0] c,
			input logic [7:0] d);
		c = c ^ {24'h000000, d};
		for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
		return c;
	endfunction

	// reference byte stream: vector bytes first, then secret bytes
	task automatic gen(input logic [23:0] v, input logic [1:0] s, input int n);
		logic [7:0] st [256];
		logic [7:0] k [32];
		logic [7:0] t, u, i, j;
		int len;
		len = klen(kl[s]);
		for (int a = 0; a < 3; a++) k[a] = v[8*a+:8];
		for (int a = 3; a < 32; a++) k[a] = sec[s][8*(a-3)+:8];
		for (int a = 0; a < 256; a++) st[a] = 8'(a);
		j = 0;
		for (int a = 0; a < 256; a++) begin
			j = j + st[a] + k[a % len];
			t = st[a];
			st[a] = st[j];
			st[j] = t;
		end
		i = 0;
		j = 0;
		for (int a = 0; a < n; a++) begin
			i = i + 1;
			j = j + st[i];
			t = st[i];
			st[i] = st[j];
			st[j] = t;
			u = st[i] + st[j];
			ks[a] = st[u];
		end
	endtask

	// byte held until accepted; valid stays up for the next byte
	task automatic send(input logic [7:0] d, input logic l);
		I_IN_VALID = 1;
		I_IN_DATA = d;
		I_IN_LAST = l;
		while (O_IN_READY !== 1'b1) @(negedge I_CLK);
		@(negedge I_CLK);
	endtask

	task automatic packet(input logic rx, input logic [1:0] s, input int n,
			input logic bad);
		logic [7:0] pt [64];
		logic [31:0] c;
		logic [23:0] v;
		logic [8:0] b;
		int m;
		int w;
		v = rx ? 24'($urandom) : tv;
		m = n + 4;
		c = 32'hffffffff;
		for (int a = 0; a < n; a++) begin
			pt[a] = 8'($urandom);
			c = crc_upd(c, pt[a]);
		end
		c = ~c;
		for (int a = 0; a < 4; a++) pt[n+a] = c[8*a+:8];
		gen(v, s, m);
		stall = 1'($urandom % 2);
		I_START = 1;
		I_DIR_RX = rx;
		I_KEY_SEL = s;
		I_RX_VECTOR = v;
		@(negedge I_CLK);
		I_START = 0;
		check({31'h0, O_BUSY}, 32'h1);
		check({8'h0, O_TX_VECTOR}, {8'h0, v});
		check({30'h0, O_TX_KEY_SEL}, {30'h0, s});
		if (!rx) begin
			tv = tv + 1;
			@(negedge I_CLK);
			I_START = 1;
			@(negedge I_CLK);
			I_START = 0;
		end
		for (int a = 0; a < (rx ? m : n); a++) begin
			send(rx ? pt[a] ^ ks[a] ^ {7'h0, bad && a == 0} : pt[a],
				a == (rx ? m : n) - 1);
		end
		I_IN_VALID = 0;
		w = 0;
		while (peer_sink_inst.beats.size() < m && w < 400) begin
			@(negedge I_CLK);
			w++;
		end
		if (rx) begin
			while (O_RX_DONE !== 1'b1 && w < 420) begin
				@(negedge I_CLK);
				w++;
			end
			check({31'h0, O_RX_DONE}, 32'h1);
			check({31'h0, O_RX_DISCARD}, {31'h0, bad});
		end
		while (O_BUSY !== 1'b0 && w < 440) begin
			@(negedge I_CLK);
			w++;
		end
		check({31'h0, O_BUSY}, 32'h0);
		for (int a = 0; a < m; a++) begin
			b = peer_sink_inst.beats.pop_front();
			if (rx) check({23'h0, b}, {23'h0, pt[a] ^ {7'h0, bad && a == 0},
				a == m - 1});
			else check({23'h0, b}, {23'h0, pt[a] ^ ks[a], a == m - 1});
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// reset, four slots of four lengths, then traffic both ways
	initial begin
		void'($urandom(75247));
		repeat (10) @(posedge I_CLK);
		@(negedge I_CLK);
		I_RESET_N = 1;
		check({8'h0, O_TX_VECTOR}, 32'h0);
		I_KEY_WR = 1;
		for (int s = 0; s < 4; s++) begin
			sec[s] = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom,
				$urandom, $urandom};
			kl[s] = 2'(s);
			I_KEY_IDX = 2'(s);
			I_KEY_LEN = 2'(s);
			I_KEY_SECRET = sec[s][crypto_pkg::SECRET_BITS-1:0];
			@(negedge I_CLK);
		end
		I_KEY_WR = 0;
		for (int s = 0; s < 4; s++) packet(0, 2'(s), 1 + s, 0);
		for (int s = 0; s < 4; s++) packet(1, 2'(3 - s), 3 + s, 0);
		packet(1, 2'h2, 2, 1);
		packet(0, 2'h1, 6, 0);
		complete_run;
	end
endmodule // testbench

`default_nettype wire
